// File: hdl/mcsr_pkg.sv
// constants for the core control and status register bank
// assumes a single 40 MHz core clock and byte-wide cpu accesses
package mcsr_pkg;

	//////////////////////////////////////////////////////////////////////
	// addressing
	localparam logic [15:0] MCSR_OFS_MAILBOX = 16'h0051;
	localparam logic [15:0] MCSR_OFS_FLAGS   = 16'h0054;
	localparam logic [15:0] MCSR_OFS_CTRL    = 16'h0055;
	localparam logic [15:0] MCSR_IO_BIAS     = 16'h0020;
	localparam logic [15:0] MCSR_IO_LIMIT    = 16'h0040;
	localparam logic [15:0] MCSR_EXT_START   = 16'h0060;

	//////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] MCSR_RST_MAILBOX = 8'h20;
	localparam logic [7:0] MCSR_RST_FLAGS   = 8'h00;
	localparam logic [7:0] MCSR_RST_CTRL    = 8'h00;

	//////////////////////////////////////////////////////////////////////
	// field positions
	localparam int MCSR_MBX_DIRTY = 7;
	localparam int MCSR_CTL_JTD   = 7;
	localparam int MCSR_CTL_BROWNOUT_SLEEP_OFF  = 6;
	localparam int MCSR_CTL_BROWNOUT_SLEEP_UNLOCK = 5;
	localparam int MCSR_CTL_PUD   = 4;
	localparam int MCSR_CTL_VECTOR_TABLE_SELECT = 1;
	localparam int MCSR_CTL_VECTOR_CHANGE_UNLOCK  = 0;
	localparam int MCSR_FLG_JTAG  = 4;
	localparam int MCSR_FLG_WDOG  = 3;
	localparam int MCSR_FLG_BROWN = 2;
	localparam int MCSR_FLG_EXT   = 1;
	localparam int MCSR_FLG_POR   = 0;
	localparam int MCSR_CAUSES    = 5;

	//////////////////////////////////////////////////////////////////////
	// cycle counts
	localparam logic [2:0] MCSR_WINDOW_CYC    = 3'h4;
	localparam logic [2:0] MCSR_BROWNOUT_SLEEP_OFF_ARM_CYC  = 3'h3;
	localparam logic [2:0] MCSR_BROWNOUT_SLEEP_OFF_HOLD_CYC = 3'h3;
	localparam logic [2:0] MCSR_BROWNOUT_SLEEP_OFF_TOTAL    = 3'(MCSR_BROWNOUT_SLEEP_OFF_ARM_CYC + MCSR_BROWNOUT_SLEEP_OFF_HOLD_CYC);

	//////////////////////////////////////////////////////////////////////
	// vector change sequence
	typedef enum logic [2:0] {
		IV_IDLE = 3'h1,
		IV_OPEN = 3'h2,
		IV_TAIL = 3'h4
	} mcsr_iv_t;

endpackage

// File: hdl/mcsr_sync2.sv
// two-stage synchroniser for a vector of independent levels
// assumes each bit is a slow level, not a multi-bit word
`timescale 1ns/100ps

module mcsr_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stable_reg;

	// no reset: the chain must keep sampling while the system reset is held
	always_ff @(posedge clk) begin
		meta_reg   <= asyncIn;
		stable_reg <= meta_reg;
	end

	assign syncOut = stable_reg;

endmodule // mcsr_sync2

// File: hdl/mcsr_regs.sv
// core control and status registers: debug mailbox, control, reset causes
// assumes cpu strobes, instruction retire and debugger clear are on clk;
// reset cause levels come from pins or other domains and are synchronised
`timescale 1ns/100ps

module mcsr_regs
	import mcsr_pkg::*;
#(
	parameter bit          MBX_SHARED     = 1'b0,
	parameter int          PORT_BITS      = 8,
	parameter int          VEC_ADDR_W     = 15,
	parameter int          FLASH_WORDS    = 16384,
	parameter int          BOOT_MIN_WORDS = 256
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [15:0]           cpuAddr,
	input  wire logic                  cpuIoSpace,
	input  wire logic                  cpuRead,
	input  wire logic                  cpuWrite,
	input  wire logic [7:0]            cpuWdata,
	output logic      [7:0]            cpuRdata,
	output logic                       cpuHit,
	output logic                       stdIoRoute,
	input  wire logic                  cpuInstrDone,
	input  wire logic                  sleepExec,
	input  wire logic                  debugEnableFuse,
	input  wire logic                  dbgAccessEnable,
	input  wire logic                  dbgClearDirty,
	output logic      [7:0]            dbgMailbox,
	output logic                       debugDataDirty,
	input  wire logic                  jtagAllowFuse,
	output logic                       jtagEnable,
	input  wire logic [MCSR_CAUSES-1:0] resetCauseRaw,
	input  wire logic [PORT_BITS-1:0]  pinDirectionBit,
	input  wire logic [PORT_BITS-1:0]  pinOutputBit,
	output logic      [PORT_BITS-1:0]  pullupEnable,
	output logic                       pullupGlobalDisable,
	input  wire logic [1:0]            bootSizeFuses,
	input  wire logic                  applicationLockBit,
	input  wire logic                  bootSectionLockBit,
	input  wire logic                  execInBoot,
	output logic      [VEC_ADDR_W-1:0] vectorBase,
	output logic                       vectorTableSelect,
	output logic                       irqBlock,
	output logic                       brownoutSleepOff,
	output logic                       brownoutDetectorOff
);

	//////////////////////////////////////////////////////////////////////
	// address decode

	// i/o space only reaches the low 64 locations, so extended ones stay data-space only
	function automatic logic decodeHit(input logic [15:0] addr, input logic io,
		input logic [15:0] ofs);
		logic [15:0] eff;
		eff = io ? 16'(addr + MCSR_IO_BIAS) : addr;
		if (io && addr >= MCSR_IO_LIMIT) begin
			return 1'b0;
		end
		return (eff == ofs) && (ofs < MCSR_EXT_START || !io);
	endfunction

	function automatic logic [VEC_ADDR_W-1:0] bootStart(input logic [1:0] fuses);
		int size;
		size = BOOT_MIN_WORDS << (2'h3 - fuses);
		return VEC_ADDR_W'(FLASH_WORDS - size);
	endfunction

	logic mbxSel;
	logic flagSel;
	logic ctrlSel;
	logic mbxVisible;
	logic mbxWr;
	logic flagWr;
	logic ctrlWr;

	always_comb begin
		mbxSel     = decodeHit(cpuAddr, cpuIoSpace, MCSR_OFS_MAILBOX);
		flagSel    = decodeHit(cpuAddr, cpuIoSpace, MCSR_OFS_FLAGS);
		ctrlSel    = decodeHit(cpuAddr, cpuIoSpace, MCSR_OFS_CTRL);
		mbxVisible = !MBX_SHARED || (debugEnableFuse && dbgAccessEnable);
		cpuHit     = (mbxSel && mbxVisible) || flagSel || ctrlSel;
		stdIoRoute = mbxSel && !mbxVisible && (cpuRead || cpuWrite);
		mbxWr      = cpuWrite && mbxSel && mbxVisible;
		flagWr     = cpuWrite && flagSel;
		ctrlWr     = cpuWrite && ctrlSel;
	end

	//////////////////////////////////////////////////////////////////////
	// debug mailbox

	logic [7:0] mbx_reg;
	logic [7:0] mbx_next;
	logic       dirty_reg;
	logic       dirty_next;

	always_comb begin
		mbx_next   = mbx_reg;
		dirty_next = dirty_reg;
		if (dbgClearDirty) begin
			dirty_next = 1'b0;
		end
		// a cpu write in the clearing cycle still leaves the flag set
		if (mbxWr) begin
			mbx_next   = cpuWdata;
			dirty_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mbx_reg   <= MCSR_RST_MAILBOX;
			dirty_reg <= 1'b0;
		end else begin
			mbx_reg   <= mbx_next;
			dirty_reg <= dirty_next;
		end
	end

	assign dbgMailbox     = mbx_reg;
	assign debugDataDirty = dirty_reg;

	//////////////////////////////////////////////////////////////////////
	// jtag disable with double-write lock

	logic       jtd_reg;
	logic       jtd_next;
	logic       jtdPend_reg;
	logic       jtdPend_next;
	logic [2:0] jtdWin_reg;
	logic [2:0] jtdWin_next;

	always_comb begin
		jtd_next     = jtd_reg;
		jtdPend_next = jtdPend_reg;
		jtdWin_next  = (jtdWin_reg != 3'h0) ? 3'(jtdWin_reg - 3'h1) : 3'h0;
		if (ctrlWr) begin
			if (jtdWin_reg != 3'h0 && cpuWdata[MCSR_CTL_JTD] == jtdPend_reg) begin
				jtd_next    = jtdPend_reg;
				jtdWin_next = 3'h0;
			end else begin
				// late or different value only re-arms the lock
				jtdPend_next = cpuWdata[MCSR_CTL_JTD];
				jtdWin_next  = MCSR_WINDOW_CYC;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			jtd_reg     <= MCSR_RST_CTRL[MCSR_CTL_JTD];
			jtdPend_reg <= 1'b0;
			jtdWin_reg  <= 3'h0;
		end else begin
			jtd_reg     <= jtd_next;
			jtdPend_reg <= jtdPend_next;
			jtdWin_reg  <= jtdWin_next;
		end
	end

	assign jtagEnable = !jtd_reg && jtagAllowFuse;

	//////////////////////////////////////////////////////////////////////
	// brown-out sleep disable

	logic       brownout_sleep_unlock_reg;
	logic       brownout_sleep_unlock_next;
	logic [2:0] bodWin_reg;
	logic [2:0] bodWin_next;
	logic [2:0] brownout_sleep_off_reg;
	logic [2:0] brownout_sleep_off_next;
	logic       bodsActive;
	logic       bodOff_reg;
	logic       bodOff_next;

	always_comb begin
		brownout_sleep_unlock_next  = brownout_sleep_unlock_reg;
		bodWin_next = (bodWin_reg != 3'h0) ? 3'(bodWin_reg - 3'h1) : 3'h0;
		brownout_sleep_off_next   = (brownout_sleep_off_reg != 3'h0) ? 3'(brownout_sleep_off_reg - 3'h1) : 3'h0;
		if (bodWin_reg == 3'h1) begin
			brownout_sleep_unlock_next = 1'b0;
		end
		if (ctrlWr) begin
			if (cpuWdata[MCSR_CTL_BROWNOUT_SLEEP_OFF] && cpuWdata[MCSR_CTL_BROWNOUT_SLEEP_UNLOCK]) begin
				brownout_sleep_unlock_next  = 1'b1;
				bodWin_next = MCSR_WINDOW_CYC;
			end else begin
				if (brownout_sleep_unlock_reg && cpuWdata[MCSR_CTL_BROWNOUT_SLEEP_OFF]) begin
					brownout_sleep_off_next = MCSR_BROWNOUT_SLEEP_OFF_TOTAL;
				end
				brownout_sleep_unlock_next  = 1'b0;
				bodWin_next = 3'h0;
			end
		end
		// effective only once the arming delay has run out
		bodsActive  = (brownout_sleep_off_reg != 3'h0) && (brownout_sleep_off_reg <= MCSR_BROWNOUT_SLEEP_OFF_HOLD_CYC);
		bodOff_next = sleepExec && bodsActive;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			brownout_sleep_unlock_reg  <= MCSR_RST_CTRL[MCSR_CTL_BROWNOUT_SLEEP_UNLOCK];
			bodWin_reg <= 3'h0;
			brownout_sleep_off_reg   <= 3'h0;
			bodOff_reg <= 1'b0;
		end else begin
			brownout_sleep_unlock_reg  <= brownout_sleep_unlock_next;
			bodWin_reg <= bodWin_next;
			brownout_sleep_off_reg   <= brownout_sleep_off_next;
			bodOff_reg <= bodOff_next;
		end
	end

	assign brownoutSleepOff    = bodsActive;
	assign brownoutDetectorOff = bodOff_reg;

	//////////////////////////////////////////////////////////////////////
	// pull-up disable

	logic pud_reg;
	logic pud_next;

	always_comb begin
		pud_next = pud_reg;
		if (ctrlWr) begin
			pud_next = cpuWdata[MCSR_CTL_PUD];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pud_reg <= MCSR_RST_CTRL[MCSR_CTL_PUD];
		end else begin
			pud_reg <= pud_next;
		end
	end

	assign pullupGlobalDisable = pud_reg;
	assign pullupEnable        = ~pinDirectionBit & pinOutputBit & {PORT_BITS{!pud_reg}};

	//////////////////////////////////////////////////////////////////////
	// interrupt vector select sequence

	mcsr_iv_t   ivState_reg;
	mcsr_iv_t   ivState_next;
	logic [2:0] ivCnt_reg;
	logic [2:0] ivCnt_next;
	logic       vector_table_select_reg;
	logic       vector_table_select_next;
	logic       vector_change_unlock_reg;
	logic       vector_change_unlock_next;
	logic       ivceSet;
	logic [VEC_ADDR_W-1:0] vecBase_reg;
	logic [VEC_ADDR_W-1:0] vecBase_next;

	always_comb begin
		ivState_next = ivState_reg;
		ivCnt_next   = (ivCnt_reg != 3'h0) ? 3'(ivCnt_reg - 3'h1) : 3'h0;
		vector_table_select_next   = vector_table_select_reg;
		vector_change_unlock_next    = vector_change_unlock_reg;
		ivceSet      = ctrlWr && cpuWdata[MCSR_CTL_VECTOR_CHANGE_UNLOCK];
		case (ivState_reg)
			IV_IDLE: begin
				if (ivceSet) begin
					ivState_next = IV_OPEN;
					ivCnt_next   = MCSR_WINDOW_CYC;
					vector_change_unlock_next    = 1'b1;
				end
			end
			IV_OPEN: begin
				if (ivceSet) begin
					ivCnt_next = MCSR_WINDOW_CYC;
				end else if (ctrlWr) begin
					vector_table_select_next   = cpuWdata[MCSR_CTL_VECTOR_TABLE_SELECT];
					vector_change_unlock_next    = 1'b0;
					ivState_next = IV_TAIL;
				end else if (ivCnt_reg == 3'h1) begin
					vector_change_unlock_next    = 1'b0;
					ivState_next = IV_IDLE;
				end
			end
			IV_TAIL: begin
				// the select write is followed by one more instruction under mask
				if (cpuInstrDone) begin
					ivState_next = IV_IDLE;
				end
			end
			default: begin
				ivState_next = IV_IDLE;
				vector_change_unlock_next    = 1'b0;
			end
		endcase
		vecBase_next = vector_table_select_reg ? bootStart(bootSizeFuses) : '0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ivState_reg <= IV_IDLE;
			ivCnt_reg   <= 3'h0;
			vector_table_select_reg   <= MCSR_RST_CTRL[MCSR_CTL_VECTOR_TABLE_SELECT];
			vector_change_unlock_reg    <= MCSR_RST_CTRL[MCSR_CTL_VECTOR_CHANGE_UNLOCK];
			vecBase_reg <= '0;
		end else begin
			ivState_reg <= ivState_next;
			ivCnt_reg   <= ivCnt_next;
			vector_table_select_reg   <= vector_table_select_next;
			vector_change_unlock_reg    <= vector_change_unlock_next;
			vecBase_reg <= vecBase_next;
		end
	end

	assign vectorTableSelect = vector_table_select_reg;
	assign vectorBase        = vecBase_reg;

	// separate block line: the global enable bit stays with the core, untouched here
	always_comb begin
		irqBlock = (ivState_reg != IV_IDLE) || (ivState_reg == IV_IDLE && ivceSet);
		if (vector_table_select_reg && applicationLockBit && !execInBoot) begin
			irqBlock = 1'b1;
		end
		if (!vector_table_select_reg && bootSectionLockBit && execInBoot) begin
			irqBlock = 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// reset cause flags

	logic [MCSR_CAUSES-1:0] cause;
	logic [MCSR_CAUSES-1:0] flags_reg;
	logic [MCSR_CAUSES-1:0] flags_next;

	mcsr_sync2 #(
		.WIDTH   (MCSR_CAUSES)
	) u_causeSync (
		.clk     (clk),
		.asyncIn (resetCauseRaw),
		.syncOut (cause)
	);

	// flags must outlive the system reset, so rst_n does not clear them
	always_comb begin
		flags_next = flags_reg;
		if (flagWr) begin
			flags_next = flags_reg & cpuWdata[MCSR_CAUSES-1:0];
		end
		if (cause[MCSR_FLG_POR]) begin
			flags_next = MCSR_RST_FLAGS[MCSR_CAUSES-1:0];
		end
		// set wins over a software clear in the same cycle
		flags_next = flags_next | cause;
	end

	always_ff @(posedge clk) begin
		flags_reg <= flags_next;
	end

	//////////////////////////////////////////////////////////////////////
	// read data

	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	always_comb begin
		rdata_next = rdata_reg;
		if (cpuRead) begin
			rdata_next = 8'h00;
			if (mbxSel && mbxVisible) begin
				rdata_next = {dirty_reg, mbx_reg[6:0]};
			end
			if (flagSel) begin
				rdata_next = {3'h0, flags_reg};
			end
			if (ctrlSel) begin
				rdata_next = {jtd_reg, brownout_sleep_off_reg != 3'h0, brownout_sleep_unlock_reg, pud_reg, 2'h0, vector_table_select_reg, vector_change_unlock_reg};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign cpuRdata = rdata_reg;

endmodule // mcsr_regs

// File: sim/mcsr_dbg_model.sv
// behavioural debugger at the far side of the mailbox
// assumes it polls the dirty flag on clk and reads the byte directly
`timescale 1ns/100ps

module mcsr_dbg_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       dirty,
	input  wire logic [7:0] mailboxByte,
	output logic            clearDirty,
	output logic [7:0]      lastByte
);
	// slow on purpose: the cpu must still see the dirty flag for a while
	logic [2:0] waitCnt;

	initial lastByte = 8'h00;

	always @(posedge clk) begin
		if (!rst_n || !dirty) begin
			waitCnt <= 3'h0;
			clearDirty <= 1'b0;
		end else if (waitCnt == 3'h5) begin
			lastByte <= mailboxByte;
			clearDirty <= 1'b1;
			waitCnt <= 3'h0;
		end else begin
			waitCnt <= waitCnt + 3'h1;
			clearDirty <= 1'b0;
		end
	end
endmodule // mcsr_dbg_model

// File: sim/mcsr_regs_sva.sv
// port assertions for the control and status register bank
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps

module mcsr_regs_sva
	import mcsr_pkg::*;
#(
	parameter int PORT_BITS  = 8,
	parameter int VEC_ADDR_W = 15
) (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic [15:0]           cpuAddr,
	input wire logic                  cpuIoSpace,
	input wire logic                  cpuRead,
	input wire logic                  cpuWrite,
	input wire logic [7:0]            cpuWdata,
	input wire logic [7:0]            cpuRdata,
	input wire logic                  cpuHit,
	input wire logic                  sleepExec,
	input wire logic [7:0]            dbgMailbox,
	input wire logic                  debugDataDirty,
	input wire logic                  jtagAllowFuse,
	input wire logic                  jtagEnable,
	input wire logic [PORT_BITS-1:0]  pinDirectionBit,
	input wire logic [PORT_BITS-1:0]  pinOutputBit,
	input wire logic [PORT_BITS-1:0]  pullupEnable,
	input wire logic                  pullupGlobalDisable,
	input wire logic [VEC_ADDR_W-1:0] vectorBase,
	input wire logic                  vectorTableSelect,
	input wire logic                  irqBlock,
	input wire logic                  brownoutSleepOff,
	input wire logic                  brownoutDetectorOff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic mbxHit;
	logic ctlWr;
	assign mbxHit = cpuHit && cpuAddr == (cpuIoSpace ? MCSR_OFS_MAILBOX - MCSR_IO_BIAS : MCSR_OFS_MAILBOX);
	assign ctlWr  = cpuWrite && cpuHit && cpuAddr == (cpuIoSpace ? MCSR_OFS_CTRL - MCSR_IO_BIAS : MCSR_OFS_CTRL);

	a_mbx_store: assert property (cpuWrite && mbxHit |=> debugDataDirty && dbgMailbox == $past(cpuWdata))
		else $error("mailbox write not stored");
	a_mbx_read: assert property (cpuRead && mbxHit |=> cpuRdata == ({$past(debugDataDirty), 7'h00} | ($past(dbgMailbox) & 8'h7f)))
		else $error("mailbox read wrong");
	a_miss_zero: assert property (cpuRead && !cpuHit |=> cpuRdata == 8'h00)
		else $error("unclaimed read not zero");
	a_io_limit: assert property (cpuIoSpace && cpuAddr >= MCSR_IO_LIMIT |-> !cpuHit)
		else $error("io access above limit claimed");
	a_jtag_fuse: assert property (jtagEnable |-> jtagAllowFuse)
		else $error("jtag enabled without fuse");
	a_jtd_timed: assert property ($changed(jtagEnable) && $stable(jtagAllowFuse) |-> $past(ctlWr))
		else $error("jtag disable changed without write");
	a_vector_table_select_timed: assert property ($changed(vectorTableSelect) |-> $past(ctlWr))
		else $error("vector select changed without write");
	a_vector_change_unlock_mask: assert property (ctlWr && cpuWdata[0] |-> irqBlock)
		else $error("unlock write not masking");
	a_pud_kill: assert property (pullupGlobalDisable |-> pullupEnable == '0)
		else $error("pull-up on while globally disabled");
	a_pullup_map: assert property (!pullupGlobalDisable |-> pullupEnable == (~pinDirectionBit & pinOutputBit))
		else $error("pull-up pattern wrong");
	a_brownout_sleep_off_len: assert property ($rose(brownoutSleepOff) |-> brownoutSleepOff[*3] ##1 !brownoutSleepOff)
		else $error("sleep-off active span wrong");
	a_bod_sleep: assert property (brownoutDetectorOff |-> $past(sleepExec) && $past(brownoutSleepOff))
		else $error("detector off without sleep in window");
	a_vec_app: assert property (!vectorTableSelect && $stable(vectorTableSelect) |-> vectorBase == '0)
		else $error("application vectors not at flash start");
endmodule // mcsr_regs_sva

bind mcsr_regs mcsr_regs_sva #(.PORT_BITS(PORT_BITS), .VEC_ADDR_W(VEC_ADDR_W)) sva_u (.*);

// File: sim/mcsr_regs_bench.sv
// self-checking bench for the control and status register bank
// assumes the bound checker and the debugger model beside the design
`timescale 1ns/100ps

module mcsr_regs_bench;
	import mcsr_pkg::*;

	localparam int              FLASH_WORDS = 16384;
	localparam int              BOOT_WORDS  = 256;
	localparam logic [14:0]     BOOT_BASE   = 15'(FLASH_WORDS - BOOT_WORDS);

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] cpuAddr = 16'h0000;
	logic        cpuIoSpace = 1'b0;
	logic        cpuRead = 1'b0;
	logic        cpuWrite = 1'b0;
	logic [7:0]  cpuWdata = 8'h00;
	logic        cpuInstrDone = 1'b0;
	logic        sleepExec = 1'b0;
	logic        jtagAllowFuse = 1'b1;
	logic [4:0]  resetCauseRaw = 5'h01;
	logic [7:0]  pinDirectionBit = 8'h0f;
	logic [7:0]  pinOutputBit = 8'h33;
	logic        appLock = 1'b0;
	logic        bootLock = 1'b0;
	logic        execInBoot = 1'b0;
	logic        debugEnableFuse = 1'b1;
	logic        dbgAccessEnable = 1'b1;
	logic        stdIoRoute;
	logic [7:0]  cpuRdata, dbgMailbox, pullupEnable, lastByte;
	logic [14:0] vectorBase;
	logic        debugDataDirty, jtagEnable, pullupGlobalDisable, vectorTableSelect;
	logic        irqBlock, brownoutSleepOff, brownoutDetectorOff, dbgClearDirty;
	int          err_count = 0;
	int          n_compared = 0;

	always #12.5 clk = ~clk;

	// shared mailbox mode, so the routing to the standard location can be exercised
	mcsr_regs #(.MBX_SHARED(1'b1), .FLASH_WORDS(FLASH_WORDS), .BOOT_MIN_WORDS(BOOT_WORDS)) dut_u (
		.clk(clk), .rst_n(rst_n), .cpuAddr(cpuAddr), .cpuIoSpace(cpuIoSpace), .cpuRead(cpuRead),
		.cpuWrite(cpuWrite), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .cpuHit(), .stdIoRoute(stdIoRoute),
		.cpuInstrDone(cpuInstrDone), .sleepExec(sleepExec), .debugEnableFuse(debugEnableFuse),
		.dbgAccessEnable(dbgAccessEnable),
		.dbgClearDirty(dbgClearDirty), .dbgMailbox(dbgMailbox), .debugDataDirty(debugDataDirty),
		.jtagAllowFuse(jtagAllowFuse), .jtagEnable(jtagEnable), .resetCauseRaw(resetCauseRaw),
		.pinDirectionBit(pinDirectionBit), .pinOutputBit(pinOutputBit), .pullupEnable(pullupEnable),
		.pullupGlobalDisable(pullupGlobalDisable), .bootSizeFuses(2'h3), .applicationLockBit(appLock),
		.bootSectionLockBit(bootLock), .execInBoot(execInBoot), .vectorBase(vectorBase),
		.vectorTableSelect(vectorTableSelect), .irqBlock(irqBlock), .brownoutSleepOff(brownoutSleepOff),
		.brownoutDetectorOff(brownoutDetectorOff));

	mcsr_dbg_model dbg_u (.clk(clk), .rst_n(rst_n), .dirty(debugDataDirty), .mailboxByte(dbgMailbox),
		.clearDirty(dbgClearDirty), .lastByte(lastByte));

	////////////////////////////////////////
	task automatic tally_and_finish();
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic io, input logic [7:0] d);
		@(posedge clk);
		cpuAddr <= a;
		cpuIoSpace <= io;
		cpuWdata <= d;
		cpuWrite <= 1'b1;
		@(posedge clk);
		cpuWrite <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic io, input logic [7:0] exp);
		@(posedge clk);
		cpuAddr <= a;
		cpuIoSpace <= io;
		cpuRead <= 1'b1;
		@(posedge clk);
		cpuRead <= 1'b0;
		@(negedge clk);
		chk(cpuRdata, exp);
	endtask

	// counts settled high cycles; x counts as low so it cannot pass
	task automatic watch(input int cyc, output int n, output int m);
		n = 0;
		m = 0;
		repeat (cyc) begin
			@(negedge clk);
			n += (brownoutSleepOff === 1'b1);
			m += (brownoutDetectorOff === 1'b1);
		end
	endtask

	////////////////////////////////////////
	task automatic t_mailbox();
		rd(16'h0051, 1'b0, 8'h20);
		wr(16'h0031, 1'b1, 8'ha5);
		@(negedge clk);
		chk(dbgMailbox, 8'ha5);
		rd(16'h0051, 1'b0, 8'ha5);
		repeat (12) @(negedge clk);
		chk(lastByte, 8'ha5);
		rd(16'h0031, 1'b1, 8'h25);
	endtask

	task automatic t_jtag();
		wr(16'h0055, 1'b0, 8'h80);
		repeat (5) @(posedge clk);
		wr(16'h0055, 1'b0, 8'h80);
		wr(16'h0055, 1'b0, 8'h00);
		@(negedge clk);
		chk(jtagEnable, 1'b1);
		repeat (6) @(posedge clk);
		wr(16'h0055, 1'b0, 8'h80);
		wr(16'h0055, 1'b0, 8'h80);
		@(negedge clk);
		chk(jtagEnable, 1'b0);
		rd(16'h0035, 1'b1, 8'h80);
		wr(16'h0055, 1'b0, 8'h00);
		wr(16'h0055, 1'b0, 8'h00);
		@(negedge clk);
		chk(jtagEnable, 1'b1);
		@(posedge clk);
		jtagAllowFuse <= 1'b0;
		@(negedge clk);
		chk(jtagEnable, 1'b0);
		@(posedge clk);
		jtagAllowFuse <= 1'b1;
	endtask

	task automatic t_pullup();
		@(negedge clk);
		chk(pullupEnable, 8'h30);
		wr(16'h0035, 1'b1, 8'h10);
		@(negedge clk);
		chk(pullupEnable, 8'h00);
		chk(pullupGlobalDisable, 1'b1);
		wr(16'h0035, 1'b1, 8'h00);
	endtask

	task automatic t_brownout_sleep_off();
		int n;
		int m;
		wr(16'h0055, 1'b0, 8'h40);
		sleepExec <= 1'b1;
		watch(10, n, m);
		chk(16'(n), 16'h0);
		chk(16'(m), 16'h0);
		wr(16'h0055, 1'b0, 8'h60);
		wr(16'h0055, 1'b0, 8'h40);
		watch(12, n, m);
		chk(16'(n), 16'h3);
		chk(16'(m), 16'h3);
		@(posedge clk);
		sleepExec <= 1'b0;
		rd(16'h0055, 1'b0, 8'h00);
	endtask

	task automatic t_vectors();
		wr(16'h0035, 1'b1, 8'h02);
		@(negedge clk);
		chk(vectorTableSelect, 1'b0);
		wr(16'h0035, 1'b1, 8'h01);
		@(negedge clk);
		chk(irqBlock, 1'b1);
		wr(16'h0035, 1'b1, 8'h02);
		@(negedge clk);
		chk(vectorTableSelect, 1'b1);
		chk(irqBlock, 1'b1);
		@(posedge clk);
		cpuInstrDone <= 1'b1;
		@(posedge clk);
		cpuInstrDone <= 1'b0;
		@(negedge clk);
		chk(irqBlock, 1'b0);
		chk(vectorBase, BOOT_BASE);
		rd(16'h0055, 1'b0, 8'h02);
		@(posedge clk);
		appLock <= 1'b1;
		@(negedge clk);
		chk(irqBlock, 1'b1);
		@(posedge clk);
		execInBoot <= 1'b1;
		@(negedge clk);
		chk(irqBlock, 1'b0);
		@(posedge clk);
		appLock <= 1'b0;
		execInBoot <= 1'b0;
		wr(16'h0035, 1'b1, 8'h03);
		repeat (4) @(negedge clk);
		chk(irqBlock, 1'b1);
		@(negedge clk);
		chk(irqBlock, 1'b0);
		rd(16'h0035, 1'b1, 8'h02);
		wr(16'h0035, 1'b1, 8'h01);
		wr(16'h0035, 1'b1, 8'h00);
		@(posedge clk);
		cpuInstrDone <= 1'b1;
		bootLock <= 1'b1;
		execInBoot <= 1'b1;
		@(posedge clk);
		cpuInstrDone <= 1'b0;
		repeat (2) @(negedge clk);
		chk(vectorTableSelect, 1'b0);
		chk(irqBlock, 1'b1);
		chk(vectorBase, 15'h0000);
		@(posedge clk);
		bootLock <= 1'b0;
		execInBoot <= 1'b0;
	endtask

	task automatic t_flags();
		rd(16'h0054, 1'b0, 8'h01);
		@(posedge clk);
		resetCauseRaw <= 5'h1e;
		repeat (2) @(posedge clk);
		resetCauseRaw <= 5'h00;
		repeat (4) @(posedge clk);
		rd(16'h0034, 1'b1, 8'h1f);
		wr(16'h0034, 1'b1, 8'hfd);
		rd(16'h0034, 1'b1, 8'h1d);
		// a core reset must not wipe the cause history
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(16'h0054, 1'b0, 8'h1d);
		rd(16'h0051, 1'b0, 8'h20);
		@(posedge clk);
		resetCauseRaw <= 5'h01;
		repeat (5) @(posedge clk);
		resetCauseRaw <= 5'h00;
		repeat (4) @(posedge clk);
		rd(16'h0054, 1'b0, 8'h01);
		wr(16'h0054, 1'b0, 8'h00);
		rd(16'h0054, 1'b0, 8'h00);
	endtask

	task automatic t_decode();
		rd(16'h0056, 1'b0, 8'h00);
		rd(16'h0040, 1'b1, 8'h00);
		rd(16'h0035, 1'b0, 8'h00);
		wr(16'h0075, 1'b0, 8'hff);
		rd(16'h0055, 1'b0, 8'h00);
	endtask

	// route strobe only stands while the write is on the bus, so it is judged mid-cycle
	task automatic t_shared();
		@(posedge clk);
		dbgAccessEnable <= 1'b0;
		cpuAddr <= 16'h0051;
		cpuIoSpace <= 1'b0;
		cpuWdata <= 8'h3c;
		cpuWrite <= 1'b1;
		@(negedge clk);
		chk(stdIoRoute, 1'b1);
		@(posedge clk);
		cpuWrite <= 1'b0;
		rd(16'h0051, 1'b0, 8'h00);
		chk(dbgMailbox, 8'h20);
		@(posedge clk);
		dbgAccessEnable <= 1'b1;
		debugEnableFuse <= 1'b0;
		rd(16'h0031, 1'b1, 8'h00);
		@(posedge clk);
		debugEnableFuse <= 1'b1;
		rd(16'h0031, 1'b1, 8'h20);
	endtask

	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		resetCauseRaw <= 5'h00;
		t_mailbox();
		t_jtag();
		t_pullup();
		t_brownout_sleep_off();
		t_vectors();
		t_flags();
		t_decode();
		t_shared();
		tally_and_finish();
	end

	// whole run is a few hundred cycles
	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
endmodule // mcsr_regs_bench
